// [bench/dtmfh_dev_model.sv]
// Purpose: Behavioural DTMF transceiver on the parallel port
// Assumes: Port sampled on clk edges
// Notes: BURST_CYC cycles stand for one 50 ms burst
module dtmfh_dev_model #(
	parameter int BURST_CYC = 50
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic chipSel_n,
	input wire logic registerSelectLine,
	input wire logic readWrite,
	input wire logic [3:0] dataOut,
	output logic [3:0] dataIn,
	output logic deviceIrq_n,
	input wire logic rxPut,
	input wire logic [3:0] rxVal
);
	timeunit 1ns;
	timeprecision 1ps;
	logic csQ, rsQ, rwQ, bSel, early, flt, endAcc;
	logic [2:1] stat;
	logic [3:0] dQ, ctrlA, ctrlB, rxReg, txLast;
	logic [23:0] ctrlLog;
	int tmr, txCount, bWr, rxRd;
	assign endAcc = !csQ && chipSel_n;
	// Floating lines toggle
	assign dataIn = (!chipSel_n && readWrite) ? (registerSelectLine ?
		{1'b0, stat, |stat} : rxReg) : {4{flt}};
	assign deviceIrq_n = !(ctrlA[2] && |stat);
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			{csQ, rsQ, rwQ, bSel, early, flt, stat} <= 8'hE0;
			{dQ, ctrlA, ctrlB, rxReg, txLast, ctrlLog} <= 44'h0;
			{tmr, txCount, bWr, rxRd} <= 128'h0;
		end
		else
		begin
			{csQ, rsQ, rwQ, dQ} <= {chipSel_n, registerSelectLine,
				readWrite, dataOut};
			flt <= !flt;
			if (tmr > 0)
				tmr <= tmr - 1;
			if (endAcc && rwQ && rsQ)
				stat <= 2'h0;
			if (endAcc && rwQ && !rsQ)
				rxRd <= rxRd + 1;
			if (endAcc && !rwQ && rsQ)
			begin
				ctrlLog <= {ctrlLog[19:0], dQ};
				bSel <= !bSel && dQ[3];
				bWr <= bWr + int'(bSel);
				if (bSel)
					ctrlB <= dQ;
				else
					ctrlA <= dQ;
			end
			if (endAcc && !rwQ && !rsQ)
			begin
				txLast <= dQ;
				txCount <= txCount + 1;
				early <= early | (tmr != 0);
				tmr <= ctrlB[0] ? 0 : (ctrlA[1] ? 4 : 2) * BURST_CYC;
				stat[1] <= 1'b0;
			end
			if (tmr == 1)
				stat[1] <= 1'b1;
			if (rxPut)
				{rxReg, stat[2]} <= {rxVal, 1'b1};
		end
endmodule // dtmfh_dev_model

// [bench/dtmfh_host_chk.sv]
// Purpose: Port checks for the DTMF host controller
// Assumes: ACC_CYC of 4
// Notes: Bound to dtmfh_host
module dtmfh_host_chk #(
	parameter int PWRUP_CYC = 20
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic chipSel_n,
	input wire logic registerSelectLine,
	input wire logic readWrite,
	input wire logic [3:0] dataOut,
	input wire logic dataOe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			cnt <= 0;
		else if (cnt < PWRUP_CYC)
			cnt <= cnt + 1;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_rdFloat; !chipSel_n && readWrite |-> dataOe_n; endproperty
	a_rdFloat: assert property (p_rdFloat)
		else $error("Data driven in read");
	property p_wrDrive; !chipSel_n && !readWrite |-> !dataOe_n; endproperty
	a_wrDrive: assert property (p_wrDrive)
		else $error("Data not driven in write");
	property p_hold; !chipSel_n |-> $stable({registerSelectLine,
		readWrite, dataOut}); endproperty
	a_hold: assert property (p_hold)
		else $error("Port moved in access");
	property p_len; $fell(chipSel_n) |-> !chipSel_n[*5] ##1 chipSel_n;
		endproperty
	a_len: assert property (p_len)
		else $error("Access length wrong");
	property p_gap; $rose(chipSel_n) |-> chipSel_n[*2]; endproperty
	a_gap: assert property (p_gap)
		else $error("Accesses too close");
	property p_rel; $rose(chipSel_n) |-> readWrite && dataOe_n; endproperty
	a_rel: assert property (p_rel)
		else $error("Port not released");
	property p_ctl; !chipSel_n && !readWrite && registerSelectLine |->
		dataOut inside {4'h0, 4'h8, 4'hD}; endproperty
	a_ctl: assert property (p_ctl)
		else $error("Bad control value");
	property p_pwr; cnt < PWRUP_CYC - 1 |-> chipSel_n; endproperty
	a_pwr: assert property (p_pwr)
		else $error("Access before power delay");
endmodule // dtmfh_host_chk

bind dtmfh_host dtmfh_host_chk #(.PWRUP_CYC(PWRUP_CYC)) dtmfh_host_chk_i (
	.clk(clk), .rst_n(rst_n), .chipSel_n(chipSel_n),
	.registerSelectLine(registerSelectLine), .readWrite(readWrite),
	.dataOut(dataOut), .dataOe_n(dataOe_n)
);

// [bench/tb_top.sv]
// Purpose: Self-checking bench for the DTMF host controller
// Assumes: One AHB-Lite slave, scaled timing
// Notes: Far side is a behavioural model
`include "dtmfh_map.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, hsel, hwrite, hreadyout, irq, chipSel_n, rxPut;
	logic registerSelectLine, readWrite, dataOe_n, deviceIrq_n, hresp;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [31:0] hwdata, hrdata, rv;
	logic [3:0] dataOut, dataIn, rxVal;
	int miscompares, checks;
	dtmfh_host #(.PWRUP_CYC(20), .ACC_CYC(4), .POLL_CYC(4)) dtmfh_host_i (
		.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .irq(irq), .chipSel_n(chipSel_n),
		.registerSelectLine(registerSelectLine), .readWrite(readWrite),
		.dataOut(dataOut), .dataOe_n(dataOe_n), .dataIn(dataIn),
		.deviceIrq_n(deviceIrq_n));
	dtmfh_dev_model #(.BURST_CYC(50)) dev (.clk(clk), .rst_n(rst_n),
		.chipSel_n(chipSel_n), .registerSelectLine(registerSelectLine),
		.readWrite(readWrite), .dataOut(dataOut), .dataIn(dataIn),
		.deviceIrq_n(deviceIrq_n), .rxPut(rxPut), .rxVal(rxVal));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic ahb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		{hsel, haddr, hwrite, htrans} <= {1'b1, a, wr, 2'h2};
		@(posedge clk);
		while (!hreadyout) @(posedge clk);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		@(posedge clk);
		while (!hreadyout) @(posedge clk);
		rv = hrdata;
	endtask
	task automatic waitEv(input int b);
		int n;
		n = 0;
		rv = 32'h0;
		while (rv[b] !== 1'b1 && n < 3000)
		begin
			ahb(1'b0, `DTMFH_OFF_IRQST, 32'h0);
			n++;
		end
		check(rv[b], 1'b1);
	endtask
	task automatic waitTx(input int c);
		int n;
		n = 0;
		while (dev.txCount < c && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		check(dev.txCount, c);
	endtask
	task automatic irqIs(input logic e);
		@(negedge clk);
		check(irq, e);
		@(posedge clk);
	endtask
	task automatic send(input logic [3:0] d);
		ahb(1'b1, `DTMFH_OFF_TXDIG, {28'h0, d});
		ahb(1'b1, `DTMFH_OFF_CMD, 32'h2);
	endtask
	task automatic t_reset();
		check(irq, 1'b0);
		ahb(1'b0, 12'hFF0, 32'h0);
		check(rv, 32'h0);
		ahb(1'b0, `DTMFH_OFF_IRQST, 32'h0);
		check(rv, 32'h0);
		check(chipSel_n, 1'b1);
		check({hreadyout, hresp}, 2'h2);
	endtask
	task automatic t_init();
		waitEv(`DTMFH_EV_INITDONE);
		check(dev.ctrlLog, 32'h0080D0);
		check(dev.bWr, 2);
		check(dev.ctrlA, 4'hD);
		ahb(1'b1, `DTMFH_OFF_IRQST, 32'h7);
		ahb(1'b1, `DTMFH_OFF_IRQMSK, 32'h7);
		irqIs(1'b0);
	endtask
	task automatic t_send();
		send(4'h7);
		waitTx(1);
		check(dev.txLast, 4'h7);
		send(4'h5);
		waitTx(2);
		check(dev.txLast, 4'h5);
		check(dev.early, 1'b0);
		waitEv(`DTMFH_EV_TXREADY);
		irqIs(1'b1);
		ahb(1'b1, `DTMFH_OFF_IRQMSK, 32'h0);
		ahb(1'b1, `DTMFH_OFF_IRQST, 32'h7);
		irqIs(1'b0);
	endtask
	task automatic t_recv();
		{rxVal, rxPut} <= {4'h9, 1'b1};
		@(posedge clk);
		rxPut <= 1'b0;
		waitEv(`DTMFH_EV_RXDIGIT);
		irqIs(1'b0);
		ahb(1'b0, `DTMFH_OFF_RXDIG, 32'h0);
		check(rv[3:0], 4'h9);
		check(dev.rxRd, 1);
		check(dev.stat[2], 1'b0);
		ahb(1'b1, `DTMFH_OFF_IRQMSK, 32'h4);
		irqIs(1'b1);
		ahb(1'b1, `DTMFH_OFF_IRQST, 32'h4);
		irqIs(1'b0);
	endtask
	task automatic t_both();
		send(4'h3);
		waitTx(3);
		send(4'h1);
		while (dev.tmr != 2) @(posedge clk);
		{rxVal, rxPut} <= {4'h6, 1'b1};
		@(posedge clk);
		rxPut <= 1'b0;
		waitTx(4);
		waitEv(`DTMFH_EV_RXDIGIT);
		check(dev.txLast, 4'h1);
		check(dev.rxRd, 2);
		ahb(1'b0, `DTMFH_OFF_RXDIG, 32'h0);
		check(rv[3:0], 4'h6);
	endtask
	task automatic t_cmd();
		ahb(1'b1, `DTMFH_OFF_IRQST, 32'h2);
		waitEv(`DTMFH_EV_TXREADY);
		ahb(1'b0, `DTMFH_OFF_DEVST, 32'h0);
		check(rv, 32'h3);
		ahb(1'b1, `DTMFH_OFF_CMD, 32'h4);
		repeat (40) @(posedge clk);
		ahb(1'b0, `DTMFH_OFF_DEVST, 32'h0);
		check(rv, 32'h0);
		ahb(1'b0, `DTMFH_OFF_STAT, 32'h0);
		check(rv, 32'h3);
		ahb(1'b0, `DTMFH_OFF_TXDIG, 32'h0);
		check(rv, 32'h1);
		ahb(1'b1, `DTMFH_OFF_CMD, 32'h1);
		waitEv(`DTMFH_EV_INITDONE);
		check(dev.ctrlLog, 32'h0080D0);
		check(dev.bWr, 4);
	endtask
	task automatic final_report();
		$display("Checks %0d, miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		final_report();
	end
	initial
	begin
		{rst_n, hsel, hwrite, rxPut, htrans} = 6'h0;
		{haddr, hwdata, rxVal} = 48'h0;
		{miscompares, checks} = 64'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_init();
		t_send();
		t_recv();
		t_both();
		t_cmd();
		final_report();
	end
endmodule // tb_top

// [shared/dtmfh_map.svh]
// Purpose: Constants for the DTMF transceiver host port controller
// Assumes: 40 MHz system clock
// Notes: Register offsets are byte addresses on AHB-Lite
`ifndef DTMFH_MAP_SVH
`define DTMFH_MAP_SVH

// ----------------------------------------
// Own register offsets
// ----------------------------------------
`define DTMFH_OFF_CMD 12'h000
`define DTMFH_OFF_TXDIG 12'h004
`define DTMFH_OFF_RXDIG 12'h008
`define DTMFH_OFF_STAT 12'h00C
`define DTMFH_OFF_IRQST 12'h010
`define DTMFH_OFF_IRQMSK 12'h014
`define DTMFH_OFF_DEVST 12'h018

// ----------------------------------------
// Command bits
// ----------------------------------------
`define DTMFH_CMD_INIT 0
`define DTMFH_CMD_SEND 1
`define DTMFH_CMD_POLL 2

// ----------------------------------------
// Interrupt status bits
// ----------------------------------------
`define DTMFH_EV_INITDONE 0
`define DTMFH_EV_TXREADY 1
`define DTMFH_EV_RXDIGIT 2

// ----------------------------------------
// Device register selects and values
// ----------------------------------------
`define DTMFH_SEL_DATA 1'b0
`define DTMFH_SEL_CTRL 1'b1
`define DTMFH_CTRL_ZERO 4'h0
`define DTMFH_CTRL_SECOND_BANK_SELECT 4'h8
`define DTMFH_CRA_BURST 4'hD
`define DTMFH_CRB_BURST 4'h0
`define DTMFH_STAT_TXRDY 1
`define DTMFH_STAT_RXFULL 2

// ----------------------------------------
// Timing
// ----------------------------------------
`define DTMFH_CLK_HZ 40000000
`define DTMFH_PWRUP_MS 100
`define DTMFH_PWRUP_CYC ((`DTMFH_CLK_HZ / 1000) * `DTMFH_PWRUP_MS)
`define DTMFH_ACC_CYC 4
`define DTMFH_POLL_CYC 400

`endif

// [shared/dtmfh_pkg.sv]
// Purpose: Types for the DTMF transceiver host port controller
// Assumes: Nothing
// Notes: Constants live in dtmfh_map.svh
package dtmfh_pkg;

	typedef enum logic [1:0]
	{
		DTMFH_ACC_IDLE,
		DTMFH_ACC_SETUP,
		DTMFH_ACC_HOLD,
		DTMFH_ACC_DONE
	} dtmfh_acc_t;

	typedef enum logic [3:0]
	{
		DTMFH_WAIT_PWR,
		DTMFH_INIT_RD1,
		DTMFH_INIT_W1,
		DTMFH_INIT_W2,
		DTMFH_INIT_W3,
		DTMFH_INIT_W4,
		DTMFH_INIT_RD2,
		DTMFH_CFG_A,
		DTMFH_CFG_B,
		DTMFH_READY,
		DTMFH_TX_WR,
		DTMFH_ST_RD,
		DTMFH_RX_RD,
		DTMFH_POLL_GAP
	} dtmfh_seq_t;

endpackage

// [src/dtmfh_bus_cycle.sv]
// Purpose: One read or write cycle on the device's parallel port
// Assumes: Device data pins sampled synchronously to clk
// Notes: Chip select held low for a fixed number of cycles
`include "dtmfh_map.svh"

module dtmfh_bus_cycle #(
	parameter int ACC_CYC = `DTMFH_ACC_CYC
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic startRead,
	input wire logic startSel,
	input wire logic [3:0] startData,
	output logic done,
	output logic [3:0] readData,
	output logic chipSel_n,
	output logic registerSelectLine,
	output logic readWrite,
	output logic [3:0] dataOut,
	output logic dataOe_n,
	input wire logic [3:0] dataIn
);

	dtmfh_pkg::dtmfh_acc_t state;
	logic [7:0] count;

	// ----------------------------------------
	// Cycle sequencer
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= dtmfh_pkg::DTMFH_ACC_IDLE;
			count <= 8'h00;
		end
		else
		begin
			unique case (state)
				dtmfh_pkg::DTMFH_ACC_IDLE:
					if (start)
						state <= dtmfh_pkg::DTMFH_ACC_SETUP;
				dtmfh_pkg::DTMFH_ACC_SETUP:
				begin
					state <= dtmfh_pkg::DTMFH_ACC_HOLD;
					count <= 8'h00;
				end
				dtmfh_pkg::DTMFH_ACC_HOLD:
				begin
					count <= count + 8'h01;
					if (count == 8'(ACC_CYC - 1))
						state <= dtmfh_pkg::DTMFH_ACC_DONE;
				end
				dtmfh_pkg::DTMFH_ACC_DONE:
					state <= dtmfh_pkg::DTMFH_ACC_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Pin drivers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			chipSel_n <= 1'b1;
			registerSelectLine <= 1'b0;
			readWrite <= 1'b1;
			dataOut <= 4'h0;
			dataOe_n <= 1'b1;
		end
		else if (state == dtmfh_pkg::DTMFH_ACC_IDLE && start)
		begin
			registerSelectLine <= startSel;
			readWrite <= startRead;
			dataOut <= startData;
			dataOe_n <= startRead;
		end
		else if (state == dtmfh_pkg::DTMFH_ACC_SETUP)
			chipSel_n <= 1'b0;
		else if (state == dtmfh_pkg::DTMFH_ACC_DONE)
		begin
			chipSel_n <= 1'b1;
			readWrite <= 1'b1;
			dataOe_n <= 1'b1;
		end
	end

	// ----------------------------------------
	// Read capture
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			readData <= 4'h0;
		else if (state == dtmfh_pkg::DTMFH_ACC_HOLD &&
			count == 8'(ACC_CYC - 1) && readWrite)
			readData <= dataIn;
	end

	assign done = (state == dtmfh_pkg::DTMFH_ACC_DONE);

endmodule // dtmfh_bus_cycle

// [src/dtmfh_host.sv]
// Purpose: Host controller driving a DTMF transceiver parallel port
// Assumes: AHB-Lite single word transfers, one clock at 40 MHz
// Notes: Software commands init, send and status poll via registers
//
// The AHB-Lite interface to the registers is this design's own decision.
`include "dtmfh_map.svh"

// Overview of operation
// - Status read: chip select low, register select high, read high
// - Power-up: read status, write 0, 0, 8, 0, read status
// - Start that reset sequence 100 ms after power-up
// - Control A written 1101: tone, DTMF, interrupt, select B
// - Control B written 0000: burst mode, dual tone
// - Transmit load: chip select low, select low, write
// - Receive read: chip select low, select low, read high
// - Transmit ready set means next digit may be written
// - Received flag set means read the receive register
// - Both flags set: read digit and write next digit
// - After loading, wait for interrupt or poll status
module dtmfh_host #(
	parameter int PWRUP_CYC = `DTMFH_PWRUP_CYC,
	parameter int ACC_CYC = `DTMFH_ACC_CYC,
	parameter int POLL_CYC = `DTMFH_POLL_CYC
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic irq,
	output logic chipSel_n,
	output logic registerSelectLine,
	output logic readWrite,
	output logic [3:0] dataOut,
	output logic dataOe_n,
	input wire logic [3:0] dataIn,
	input wire logic deviceIrq_n
);

	dtmfh_pkg::dtmfh_seq_t seq;
	logic [31:0] pwrCount, next_hrdata;
	logic [15:0] gapCount;
	logic [11:0] wrAddr;
	logic [3:0] accData, accRdData, txDigit, rxDigit, devStatus;
	logic [2:0] irqStatus, irqMask;
	logic accStart, accRead, accSel, accDone, accBusy, wrPend, wrCmd;
	logic initReq, sendReq, pollReq, initDone, txReady;
	logic evInit, evTx, evRx, busy;

	function automatic logic isSeq(input dtmfh_pkg::dtmfh_seq_t s);
		return seq == s;
	endfunction

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wrPend <= 1'b0;
			wrAddr <= 12'h000;
		end
		else if (hready)
		begin
			wrPend <= hsel && htrans[1] && hwrite;
			wrAddr <= haddr;
		end
	end

	always_comb
	begin
		unique case (haddr)
			`DTMFH_OFF_TXDIG: next_hrdata = {28'h0000000, txDigit};
			`DTMFH_OFF_RXDIG: next_hrdata = {28'h0000000, rxDigit};
			`DTMFH_OFF_STAT: next_hrdata = {29'h00000000, busy, txReady,
				initDone};
			`DTMFH_OFF_IRQST: next_hrdata = {29'h00000000, irqStatus};
			`DTMFH_OFF_IRQMSK: next_hrdata = {29'h00000000, irqMask};
			`DTMFH_OFF_DEVST: next_hrdata = {28'h0000000, devStatus};
			default: next_hrdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			hrdata <= 32'h00000000;
		else if (hready && hsel && htrans[1] && !hwrite)
			hrdata <= next_hrdata;
	end
	assign wrCmd = wrPend && wrAddr == `DTMFH_OFF_CMD;
	assign busy = seq != dtmfh_pkg::DTMFH_READY;

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txDigit <= 4'h0;
			irqMask <= 3'h0;
		end
		else if (wrPend)
		begin
			if (wrAddr == `DTMFH_OFF_TXDIG)
				txDigit <= hwdata[3:0];
			if (wrAddr == `DTMFH_OFF_IRQMSK)
				irqMask <= hwdata[2:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			initReq <= 1'b0;
			sendReq <= 1'b0;
			pollReq <= 1'b0;
		end
		else
		begin
			if (wrCmd && hwdata[`DTMFH_CMD_INIT])
				initReq <= 1'b1;
			else if (isSeq(dtmfh_pkg::DTMFH_WAIT_PWR) && pwrCount == 32'h0)
				initReq <= 1'b0;
			if (wrCmd && hwdata[`DTMFH_CMD_SEND])
				sendReq <= 1'b1;
			else if (isSeq(dtmfh_pkg::DTMFH_TX_WR) && accDone)
				sendReq <= 1'b0;
			if (wrCmd && hwdata[`DTMFH_CMD_POLL])
				pollReq <= 1'b1;
			else if (isSeq(dtmfh_pkg::DTMFH_ST_RD) && accDone)
				pollReq <= 1'b0;
		end
	end

	// ----------------------------------------
	// Device port sequencer
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			seq <= dtmfh_pkg::DTMFH_WAIT_PWR;
			pwrCount <= 32'(PWRUP_CYC);
			gapCount <= 16'h0000;
		end
		else
		begin
			unique case (seq)
				dtmfh_pkg::DTMFH_WAIT_PWR:
					if (pwrCount != 32'h0)
						pwrCount <= pwrCount - 32'h1;
					else
						seq <= dtmfh_pkg::DTMFH_INIT_RD1;
				dtmfh_pkg::DTMFH_INIT_RD1:
					if (accDone) seq <= dtmfh_pkg::DTMFH_INIT_W1;
				dtmfh_pkg::DTMFH_INIT_W1:
					if (accDone) seq <= dtmfh_pkg::DTMFH_INIT_W2;
				dtmfh_pkg::DTMFH_INIT_W2:
					if (accDone) seq <= dtmfh_pkg::DTMFH_INIT_W3;
				dtmfh_pkg::DTMFH_INIT_W3:
					if (accDone) seq <= dtmfh_pkg::DTMFH_INIT_W4;
				dtmfh_pkg::DTMFH_INIT_W4:
					if (accDone) seq <= dtmfh_pkg::DTMFH_INIT_RD2;
				dtmfh_pkg::DTMFH_INIT_RD2:
					if (accDone) seq <= dtmfh_pkg::DTMFH_CFG_A;
				dtmfh_pkg::DTMFH_CFG_A:
					if (accDone) seq <= dtmfh_pkg::DTMFH_CFG_B;
				dtmfh_pkg::DTMFH_CFG_B:
					if (accDone) seq <= dtmfh_pkg::DTMFH_READY;
				dtmfh_pkg::DTMFH_READY:
					if (initReq)
					begin
						seq <= dtmfh_pkg::DTMFH_WAIT_PWR;
						pwrCount <= 32'h0;
					end
					else if (sendReq && txReady)
						seq <= dtmfh_pkg::DTMFH_TX_WR;
					else if (pollReq || !deviceIrq_n)
						seq <= dtmfh_pkg::DTMFH_ST_RD;
				dtmfh_pkg::DTMFH_TX_WR:
					if (accDone) seq <= dtmfh_pkg::DTMFH_READY;
				dtmfh_pkg::DTMFH_ST_RD:
					if (accDone)
					begin
						if (accRdData[`DTMFH_STAT_RXFULL])
							seq <= dtmfh_pkg::DTMFH_RX_RD;
						else
						begin
							seq <= dtmfh_pkg::DTMFH_POLL_GAP;
							gapCount <= 16'(POLL_CYC);
						end
					end
				dtmfh_pkg::DTMFH_RX_RD:
					if (accDone)
					begin
						seq <= dtmfh_pkg::DTMFH_POLL_GAP;
						gapCount <= 16'(POLL_CYC);
					end
				dtmfh_pkg::DTMFH_POLL_GAP:
					if (gapCount != 16'h0)
						gapCount <= gapCount - 16'h1;
					else
						seq <= dtmfh_pkg::DTMFH_READY;
				default: seq <= dtmfh_pkg::DTMFH_WAIT_PWR;
			endcase
		end
	end

	always_comb
	begin
		accRead = 1'b0;
		accSel = `DTMFH_SEL_CTRL;
		accData = `DTMFH_CTRL_ZERO;
		unique case (seq)
			dtmfh_pkg::DTMFH_INIT_RD1,
			dtmfh_pkg::DTMFH_INIT_RD2,
			dtmfh_pkg::DTMFH_ST_RD:
				accRead = 1'b1;
			dtmfh_pkg::DTMFH_INIT_W3:
				accData = `DTMFH_CTRL_SECOND_BANK_SELECT;
			dtmfh_pkg::DTMFH_CFG_A:
				accData = `DTMFH_CRA_BURST;
			dtmfh_pkg::DTMFH_CFG_B:
				accData = `DTMFH_CRB_BURST;
			dtmfh_pkg::DTMFH_TX_WR:
			begin
				accSel = `DTMFH_SEL_DATA;
				accData = txDigit;
			end
			dtmfh_pkg::DTMFH_RX_RD:
			begin
				accSel = `DTMFH_SEL_DATA;
				accRead = 1'b1;
			end
			default: accData = `DTMFH_CTRL_ZERO;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			accBusy <= 1'b0;
		else if (accStart)
			accBusy <= 1'b1;
		else if (accDone)
			accBusy <= 1'b0;
	end

	assign accStart = !accBusy && !accDone &&
		seq != dtmfh_pkg::DTMFH_WAIT_PWR && seq != dtmfh_pkg::DTMFH_READY &&
		seq != dtmfh_pkg::DTMFH_POLL_GAP;

	dtmfh_bus_cycle #(.ACC_CYC(ACC_CYC)) u_cycle (
		.clk(clk),
		.rst_n(rst_n),
		.start(accStart),
		.startRead(accRead),
		.startSel(accSel),
		.startData(accData),
		.done(accDone),
		.readData(accRdData),
		.chipSel_n(chipSel_n),
		.registerSelectLine(registerSelectLine),
		.readWrite(readWrite),
		.dataOut(dataOut),
		.dataOe_n(dataOe_n),
		.dataIn(dataIn)
	);

	// ----------------------------------------
	// Device state tracking
	// ----------------------------------------
	assign evInit = seq == dtmfh_pkg::DTMFH_CFG_B && accDone;
	assign evTx = seq == dtmfh_pkg::DTMFH_ST_RD && accDone &&
		accRdData[`DTMFH_STAT_TXRDY];
	assign evRx = seq == dtmfh_pkg::DTMFH_RX_RD && accDone;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			initDone <= 1'b0;
			txReady <= 1'b0;
			devStatus <= 4'h0;
			rxDigit <= 4'h0;
		end
		else
		begin
			if (evInit)
				initDone <= 1'b1;
			else if (isSeq(dtmfh_pkg::DTMFH_INIT_RD1))
				initDone <= 1'b0;
			// Status read clears device flags, so keep a local copy
			if (evInit || evTx)
				txReady <= 1'b1;
			else if (isSeq(dtmfh_pkg::DTMFH_TX_WR) && accDone)
				txReady <= 1'b0;
			if (isSeq(dtmfh_pkg::DTMFH_ST_RD) && accDone)
				devStatus <= accRdData;
			if (evRx)
				rxDigit <= accRdData;
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irqStatus <= 3'h0;
		else
			irqStatus <= (irqStatus & ~((wrPend && wrAddr == `DTMFH_OFF_IRQST)
				? hwdata[2:0] : 3'h0)) | {evRx, evTx, evInit};
	end
	assign irq = |(irqStatus & irqMask);

endmodule // dtmfh_host
